// ---- bench/tq_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
module tq_sink (
    // clock and reset
    input  wire logic CLK,
    input  wire logic RESETN,
    // stall select and handshake
    input  wire logic SLOW,
    output logic      OUT_READY
);
    logic [7:0] lfsr_ff;
    // own stall pattern, so stalls do not track the bench's stimulus
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            lfsr_ff   <= 8'h5a;
            OUT_READY <= 1'b0;
        end else begin
            lfsr_ff   <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
            OUT_READY <= !SLOW || lfsr_ff[0];
        end
    end
endmodule
`default_nettype wire

// ---- bench/tq_tess_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module tq_tess_asserts
    import tq_pkg::*;
(
    // clock, reset, read data
    input wire logic             CLK,
    input wire logic             RESETN,
    input wire logic             REG_RD,
    input wire logic [31:0]      REG_RDATA,
    // handshakes
    input wire logic             IN_VALID,
    input wire logic             IN_READY,
    input wire logic             OUT_VALID,
    input wire logic             OUT_READY,
    // primitive
    input wire logic             OUT_IS_LINE,
    input wire logic [CRD_W-1:0] OUT_U0,
    input wire logic [CRD_W-1:0] OUT_V0,
    input wire logic [CRD_W-1:0] OUT_U1,
    input wire logic [CRD_W-1:0] OUT_V1,
    input wire logic [CRD_W-1:0] OUT_U2,
    input wire logic [CRD_W-1:0] OUT_V2
);
    // single domain, so clock and reset are given once
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    property p_hold; OUT_VALID && !OUT_READY |=>
        OUT_VALID && $stable(OUT_U0); endproperty
    a_hold: assert property (p_hold) else $error("stall lost");
    property p_rdz; !REG_RD |=> REG_RDATA == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("stray rdata");
    property p_acc; IN_VALID && IN_READY |=> !IN_READY; endproperty
    a_acc: assert property (p_acc) else $error("ready kept");
    property p_ans; IN_VALID && IN_READY |-> ##2 OUT_VALID; endproperty
    a_ans: assert property (p_ans) else $error("no output");
    property p_lv; OUT_VALID && OUT_IS_LINE |-> OUT_V0 == OUT_V1; endproperty
    a_lv: assert property (p_lv) else $error("slanted line");
    property p_top; OUT_VALID && OUT_IS_LINE |-> OUT_V0 < CRD_ONE; endproperty
    a_top: assert property (p_top) else $error("top line");
    property p_lcp; OUT_VALID && OUT_IS_LINE |->
        OUT_U2 == OUT_U1 && OUT_V2 == OUT_V1; endproperty
    a_lcp: assert property (p_lcp) else $error("bad copy");
    property p_rng; OUT_VALID |-> OUT_U0 <= CRD_ONE && OUT_V0 <= CRD_ONE;
    endproperty
    a_rng: assert property (p_rng) else $error("off domain");
endmodule
bind tq_tess tq_tess_asserts tq_tess_asserts_inst (.CLK(CLK),
    .RESETN(RESETN), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_IS_LINE(OUT_IS_LINE), .OUT_U0(OUT_U0),
    .OUT_V0(OUT_V0), .OUT_U1(OUT_U1), .OUT_V1(OUT_V1), .OUT_U2(OUT_U2),
    .OUT_V2(OUT_V2));
`default_nettype wire

// ---- bench/tq_tess_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tq_tess_tb
    import tq_pkg::*;
;
    typedef struct {int cnt; int l; int s; bit iso; bit cw;} tq_note_t;
    logic clk, rstn, wr, rd, rd_q, iv, ir, ov, ordy, isl, last, slow;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata, rdata, seed;
    logic [LVL_W-1:0]  lv [6];
    logic [CRD_W-1:0]  u0, v0, u1, v1, u2, v2;
    tq_note_t          nq [$];
    logic [31:0]       rq [$];
    int                n_fail, checks_done, pi;
    longint            asum, a;

    tq_tess tq_tess_inst (.CLK(clk), .RESETN(rstn), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .IN_VALID(iv), .IN_READY(ir), .IN_INNER0(lv[0]), .IN_INNER1(lv[1]),
        .IN_OUTER0(lv[2]), .IN_OUTER1(lv[3]), .IN_OUTER2(lv[4]),
        .IN_OUTER3(lv[5]), .OUT_VALID(ov), .OUT_READY(ordy),
        .OUT_IS_LINE(isl), .OUT_LAST(last), .OUT_U0(u0), .OUT_V0(v0),
        .OUT_U1(u1), .OUT_V1(v1), .OUT_U2(u2), .OUT_V2(v2));
    tq_sink tq_sink_inst (.CLK(clk), .RESETN(rstn), .SLOW(slow),
        .OUT_READY(ordy));

    // bench clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // twice the signed area in fixed point
    function automatic longint ar(longint x0, y0, x1, y1, x2, y2);
        return x0 * y1 - x1 * y0 + x1 * y2 - x2 * y1 + x2 * y0 - x0 * y2;
    endfunction

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic conclude();
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one register cycle; a read notes its expected data
    task automatic bus(input logic w, input logic [3:0] ad, logic [31:0] d);
        if (!w) rq.push_back(d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // levels below one count as one; an inner one splits by spacing
    task automatic patch(input bit iso, int sp, bit cw, int l[6]);
        tq_note_t nt;
        int m, n, o = 0;
        foreach (l[i]) l[i] = (l[i] < 1) ? 1 : l[i];
        m = (l[0] == 1) ? ((sp == 2) ? 3 : 2) : l[0];
        n = (l[1] == 1) ? ((sp == 2) ? 3 : 2) : l[1];
        for (int i = 2; i < 6; i++) o += l[i];
        nt.cnt = (l.sum() == 6) ? 2 : 2 * (m - 2) * (n - 2) + o + 2 * (m + n - 4);
        if (iso) nt.cnt = l[2] * l[3];
        nt.l = l[2];
        nt.s = l[3];
        nt.iso = iso;
        nt.cw = cw;
        bus(1'b1, REG_CTRL_OFS, {28'h0, cw, sp[1:0], iso});
        // count runs on across patches, so clear it before each one
        bus(1'b1, REG_COUNT_OFS, 32'h0);
        nq.push_back(nt);
        @(posedge clk);
        foreach (l[i]) lv[i] <= LVL_W'(l[i]);
        iv <= 1'b1;
        do @(posedge clk); while (ir !== 1'b1);
        iv <= 1'b0;
        for (int t = 0; t < 4000 && nq.size() > 0; t++) @(posedge clk);
        chk(nq.size() == 0, "patch hang");
        bus(1'b0, REG_COUNT_OFS, 32'(nt.cnt));
        bus(1'b0, REG_STATUS_OFS, 32'h2);
    endtask

    // checks read data and each delivered primitive against the notes
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q) chk(rdata === rq.pop_front(), "rdata");
        if (ov === 1'b1 && ordy === 1'b1 && nq.size() > 0) begin
            a = ar(u0, v0, u1, v1, u2, v2);
            if (nq[0].iso) begin
                chk(isl === 1'b1 && v0 === CRD_W'((pi / nq[0].s << 15)
                    / nq[0].l), "line v");
                chk(u0 === CRD_W'((pi % nq[0].s << 15) / nq[0].s) && u1 ===
                    CRD_W'(((pi % nq[0].s + 1) << 15) / nq[0].s),
                    "line u");
            end else begin
                chk(!isl && (nq[0].cw ? a <= 0 : a >= 0), "wind");
                asum += a;
            end
            pi++;
            if (last === 1'b1) begin
                chk(pi == nq[0].cnt, "count");
                chk(nq[0].iso || asum == (nq[0].cw ? -1 : 1) *
                    (64'sd1 << 31), "cover");
                void'(nq.pop_front());
                pi = 0;
                asum = 0;
            end
        end
    end

    // main sequence
    initial begin
        int r[6];
        seed = 32'd40;
        {rstn, iv, wr, rd, slow, addr, wdata} = '0;
        foreach (lv[i]) lv[i] = '0;
        {n_fail, checks_done, pi, asum} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, REG_CTRL_OFS, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        patch(0, 0, 0, '{1, 1, 1, 1, 1, 1});
        patch(0, 0, 1, '{3, 5, 1, 2, 3, 4});
        patch(0, 1, 0, '{1, 4, 2, 1, 3, 5});
        patch(0, 2, 1, '{1, 1, 2, 2, 2, 2});
        patch(1, 2, 0, '{4, 9, 3, 5, 7, 7});
        slow <= 1'b1;
        repeat (6) begin
            foreach (r[i]) r[i] = xs() % 6 + 1;
            patch(xs() % 2, xs() % 3, xs() % 2, r);
        end
        conclude();
    end

    // cut a hang short
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire

// ---- hw/tq_coord.sv ----
`timescale 1ns/10ps
`default_nettype none
module tq_coord
    import tq_pkg::*;
(
    // subdivision point request
    input  wire logic [LVL_W-1:0] idx,
    input  wire logic [LVL_W-1:0] cnt,
    input  wire logic             eps,
    // resulting parameter coordinate
    output logic      [CRD_W-1:0] coord
);

    logic [LVL_W+DIV_SHIFT-1:0] num;
    logic [LVL_W+DIV_SHIFT-1:0] quo;

    // plain division; a long path traded for zero latency
    always_comb begin
        num = {idx, {DIV_SHIFT{1'b0}}};
        quo = (cnt == '0) ? '0 : num / {{DIV_SHIFT{1'b0}}, cnt};
        if (eps) begin
            // odd 1+eps split: two tiny end pieces collapse onto the edge
            coord = (idx < 7'h02) ? CRD_ZERO : CRD_ONE;
        end else if (idx >= cnt) begin
            coord = CRD_ONE;
        end else begin
            coord = quo[CRD_W-1:0];
        end
    end

endmodule
`default_nettype wire

// ---- hw/tq_pkg.sv ----
package tq_pkg;

    // level and coordinate widths
    localparam int LVL_W = 7;
    localparam int CRD_W = 16;
    localparam int NVERT = 3;
    localparam int DIV_SHIFT = 15;
    // coordinate 1.0 in unsigned 1.15 fixed point
    localparam logic [CRD_W-1:0] CRD_ONE = 16'h8000;
    localparam logic [CRD_W-1:0] CRD_ZERO = 16'h0000;

    // register map on the plain register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_COUNT_OFS = 4'h8;
    localparam int CTRL_ISO_BIT = 0;
    localparam int CTRL_SP_LSB = 1;
    localparam int CTRL_CW_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_IDLE_BIT = 1;

    // spacing modes
    typedef enum logic [1:0] {
        SP_EQUAL     = 2'b00,
        SP_FRAC_EVEN = 2'b01,
        SP_FRAC_ODD  = 2'b10
    } tq_spacing_t;

    // generator states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ONES  = 3'b001,
        ST_INNER = 3'b010,
        ST_RING  = 3'b011,
        ST_ISO   = 3'b100
    } tq_state_t;

    // one coordinate axis: index into a subdivision of cnt segments
    typedef struct packed {
        logic [LVL_W-1:0] idx;
        logic [LVL_W-1:0] cnt;
        logic             eps;
    } tq_axis_t;

    typedef struct packed {
        tq_axis_t u;
        tq_axis_t v;
    } tq_vert_t;

endpackage

// ---- hw/tq_tess.sv ----
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module tq_tess
    import tq_pkg::*;
(
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             RESETN,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [31:0]      REG_WDATA,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    output logic      [31:0]      REG_RDATA,
    // patch levels in, clamped and rounded here
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [LVL_W-1:0] IN_INNER0,
    input  wire logic [LVL_W-1:0] IN_INNER1,
    input  wire logic [LVL_W-1:0] IN_OUTER0,
    input  wire logic [LVL_W-1:0] IN_OUTER1,
    input  wire logic [LVL_W-1:0] IN_OUTER2,
    input  wire logic [LVL_W-1:0] IN_OUTER3,
    // primitive stream out
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic                  OUT_IS_LINE,
    output logic                  OUT_LAST,
    output logic      [CRD_W-1:0] OUT_U0,
    output logic      [CRD_W-1:0] OUT_V0,
    output logic      [CRD_W-1:0] OUT_U1,
    output logic      [CRD_W-1:0] OUT_V1,
    output logic      [CRD_W-1:0] OUT_U2,
    output logic      [CRD_W-1:0] OUT_V2
);

    tq_state_t        state_ff, nxt_state;
    logic [LVL_W-1:0] a_ff, nxt_a, b_ff, nxt_b;
    logic [1:0]       side_ff, nxt_side;
    logic             half_ff, nxt_half;
    logic [LVL_W-1:0] m_ff, n_ff;
    logic             em_ff, en_ff;
    logic [LVL_W-1:0] out_ff [4];
    logic             iso_ff, cw_ff;
    logic [3:0]       ctrl_ff;
    logic [31:0]      count_ff, rdata_ff;
    logic             ovalid_ff, oline_ff, olast_ff;
    logic [CRD_W-1:0] ou_ff [NVERT];
    logic [CRD_W-1:0] ov_ff [NVERT];
    logic [LVL_W-1:0] l_in0, l_in1, l_out [4], nxt_m, nxt_n;
    logic             ones, odd, accept, advance, fire;
    logic [LVL_W-1:0] kk, jj, a2, b2;
    logic [15:0]      lhs, rhs;
    logic             adv_outer;
    tq_vert_t         vq [NVERT];
    logic [CRD_W-1:0] cu [NVERT];
    logic [CRD_W-1:0] cv [NVERT];
    logic [31:0]      p01, p10, p12, p21, p20, p02;
    logic signed [34:0] area;
    logic             swap;

    // level zero is treated as one
    function automatic logic [LVL_W-1:0] clamp1(input logic [LVL_W-1:0] x);
        return (x == '0) ? 7'h01 : x;
    endfunction

    function automatic tq_axis_t mk(input logic [LVL_W-1:0] i,
                                    input logic [LVL_W-1:0] c,
                                    input logic e);
        tq_axis_t r;
        r.idx = i;
        r.cnt = c;
        r.eps = e;
        return r;
    endfunction

    // ring vertex: outer side point a of k, or inner edge point
    function automatic tq_vert_t ring_pt(input logic [1:0] s,
                                         input logic outer,
                                         input logic [LVL_W-1:0] p,
                                         input logic [LVL_W-1:0] k,
                                         input logic [LVL_W-1:0] n,
                                         input logic [LVL_W-1:0] m,
                                         input logic en,
                                         input logic em);
        tq_vert_t r;
        tq_axis_t zro, one;
        zro = mk(7'h00, 7'h01, 1'b0);
        one = mk(7'h01, 7'h01, 1'b0);
        if (outer) begin
            // outer vertices from the outer levels
            case (s)
                2'h0: begin r.u = mk(p, k, 1'b0); r.v = zro; end
                2'h1: begin r.u = one; r.v = mk(p, k, 1'b0); end
                2'h2: begin r.u = mk(p, k, 1'b0); r.v = one; end
                default: begin r.u = zro; r.v = mk(p, k, 1'b0); end
            endcase
        end else begin
            // inner edge reuses grid vertices
            case (s)
                2'h0: begin
                    r.u = mk(p + 7'h01, n, en);
                    r.v = mk(7'h01, m, em);
                end
                2'h1: begin
                    r.u = mk(n - 7'h01, n, en);
                    r.v = mk(p + 7'h01, m, em);
                end
                2'h2: begin
                    r.u = mk(p + 7'h01, n, en);
                    r.v = mk(m - 7'h01, m, em);
                end
                default: begin
                    r.u = mk(7'h01, n, en);
                    r.v = mk(p + 7'h01, m, em);
                end
            endcase
        end
        return r;
    endfunction

    // patch set-up decode
    always_comb begin
        l_in0 = clamp1(IN_INNER0);
        l_in1 = clamp1(IN_INNER1);
        l_out[0] = clamp1(IN_OUTER0);
        l_out[1] = clamp1(IN_OUTER1);
        l_out[2] = clamp1(IN_OUTER2);
        l_out[3] = clamp1(IN_OUTER3);
        ones = (l_in0 == 7'h01) && (l_in1 == 7'h01) && (l_out[0] == 7'h01)
            && (l_out[1] == 7'h01) && (l_out[2] == 7'h01)
            && (l_out[3] == 7'h01);
        odd = (ctrl_ff[CTRL_SP_LSB+:2] == SP_FRAC_ODD);
        // 1+eps rounds to two, or three under odd spacing
        nxt_m = (l_in0 == 7'h01) ? (odd ? 7'h03 : 7'h02) : l_in0;
        nxt_n = (l_in1 == 7'h01) ? (odd ? 7'h03 : 7'h02) : l_in1;
    end

    assign IN_READY = (state_ff == ST_IDLE);
    assign accept = IN_VALID && IN_READY;
    // generation stalls on a full output slot
    assign advance = (state_ff != ST_IDLE) && (!ovalid_ff || OUT_READY);
    assign fire = ovalid_ff && OUT_READY;

    // per-side ring sizes and merge walk decision
    always_comb begin
        case (side_ff)
            2'h0: kk = out_ff[1];
            2'h1: kk = out_ff[2];
            2'h2: kk = out_ff[3];
            default: kk = out_ff[0];
        endcase
        // zero inner segments is the degenerate point edge
        jj = side_ff[0] ? (m_ff - 7'h02) : (n_ff - 7'h02);
        lhs = 16'({a_ff, 1'b1}) * 16'(jj);
        rhs = 16'({b_ff, 1'b1}) * 16'(kk);
        // with jj zero only outer steps run: a fan
        adv_outer = (b_ff == jj) || ((a_ff != kk) && (lhs <= rhs));
        a2 = adv_outer ? a_ff + 7'h01 : a_ff;
        b2 = adv_outer ? b_ff : b_ff + 7'h01;
    end

    // next generator state
    always_comb begin
        nxt_state = state_ff;
        nxt_a = a_ff;
        nxt_b = b_ff;
        nxt_half = half_ff;
        nxt_side = side_ff;
        if (accept) begin
            nxt_half = 1'b0;
            nxt_side = 2'h0;
            nxt_a = 7'h00;
            nxt_b = 7'h00;
            if (ctrl_ff[CTRL_ISO_BIT]) begin
                nxt_state = ST_ISO;
            end else if (ones) begin
                nxt_state = ST_ONES;
            end else if (nxt_m > 7'h02 && nxt_n > 7'h02) begin
                nxt_state = ST_INNER;
                nxt_a = 7'h01;
                nxt_b = 7'h01;
            end else begin
                nxt_state = ST_RING;
            end
        end else if (advance) begin
            case (state_ff)
                ST_ONES: begin
                    nxt_half = ~half_ff;
                    if (half_ff) begin
                        nxt_state = ST_IDLE;
                    end
                end
                ST_INNER: begin
                    nxt_half = ~half_ff;
                    if (half_ff && a_ff == n_ff - 7'h02) begin
                        nxt_a = 7'h01;
                        if (b_ff == m_ff - 7'h02) begin
                            nxt_state = ST_RING;
                            nxt_a = 7'h00;
                            nxt_b = 7'h00;
                        end else begin
                            nxt_b = b_ff + 7'h01;
                        end
                    end else if (half_ff) begin
                        nxt_a = a_ff + 7'h01;
                    end
                end
                ST_RING: begin
                    nxt_a = a2;
                    nxt_b = b2;
                    if (a2 == kk && b2 == jj) begin
                        nxt_a = 7'h00;
                        nxt_b = 7'h00;
                        nxt_side = side_ff + 2'h1;
                        if (side_ff == 2'h3) begin
                            nxt_state = ST_IDLE;
                        end
                    end
                end
                ST_ISO: begin
                    // a walks segments, b walks lines
                    if (a_ff == out_ff[1] - 7'h01) begin
                        nxt_a = 7'h00;
                        if (b_ff == out_ff[0] - 7'h01) begin
                            nxt_state = ST_IDLE;
                        end else begin
                            nxt_b = b_ff + 7'h01;
                        end
                    end else begin
                        nxt_a = a_ff + 7'h01;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // vertex requests for the primitive about to be emitted
    always_comb begin
        for (int i = 0; i < NVERT; i++) begin
            vq[i] = '0;
        end
        case (state_ff)
            ST_ONES: begin
                // unit square as two triangles
                vq[0].u = mk(7'h00, 7'h01, 1'b0);
                vq[0].v = mk(7'h00, 7'h01, 1'b0);
                vq[1].u = mk(7'h01, 7'h01, 1'b0);
                vq[1].v = mk(half_ff ? 7'h01 : 7'h00, 7'h01, 1'b0);
                vq[2].u = mk(half_ff ? 7'h00 : 7'h01, 7'h01, 1'b0);
                vq[2].v = mk(7'h01, 7'h01, 1'b0);
            end
            ST_INNER: begin
                // cell split on its diagonal
                vq[0].u = mk(a_ff, n_ff, en_ff);
                vq[0].v = mk(b_ff, m_ff, em_ff);
                vq[1].u = mk(a_ff + 7'h01, n_ff, en_ff);
                vq[1].v = mk(b_ff + (half_ff ? 7'h01 : 7'h00), m_ff, em_ff);
                vq[2].u = mk(a_ff + (half_ff ? 7'h00 : 7'h01), n_ff, en_ff);
                vq[2].v = mk(b_ff + 7'h01, m_ff, em_ff);
            end
            ST_RING: begin
                // two neighbours on one edge, apex on the other
                if (adv_outer) begin
                    vq[0] = ring_pt(side_ff, 1'b1, a_ff, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                    vq[1] = ring_pt(side_ff, 1'b1, a_ff + 7'h01, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                    vq[2] = ring_pt(side_ff, 1'b0, b_ff, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                end else begin
                    vq[0] = ring_pt(side_ff, 1'b0, b_ff, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                    vq[1] = ring_pt(side_ff, 1'b0, b_ff + 7'h01, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                    vq[2] = ring_pt(side_ff, 1'b1, a_ff, kk,
                                    n_ff, m_ff, en_ff, em_ff);
                end
            end
            ST_ISO: begin
                // v is b over lines, b below lines so v=1 never
                vq[0].u = mk(a_ff, out_ff[1], 1'b0);
                vq[0].v = mk(b_ff, out_ff[0], 1'b0);
                vq[1].u = mk(a_ff + 7'h01, out_ff[1], 1'b0);
                vq[1].v = mk(b_ff, out_ff[0], 1'b0);
                vq[2] = vq[1];
            end
            default: ;
        endcase
    end

    // coordinate units, two per vertex
    for (genvar g = 0; g < NVERT; g++) begin : g_crd
        tq_coord u_cu (
            .idx   (vq[g].u.idx),
            .cnt   (vq[g].u.cnt),
            .eps   (vq[g].u.eps),
            .coord (cu[g])
        );
        tq_coord u_cv (
            .idx   (vq[g].v.idx),
            .cnt   (vq[g].v.cnt),
            .eps   (vq[g].v.eps),
            .coord (cv[g])
        );
    end

    // winding from signed area, then swap to the selected order
    always_comb begin
        p01 = cu[0] * cv[1];
        p10 = cu[1] * cv[0];
        p12 = cu[1] * cv[2];
        p21 = cu[2] * cv[1];
        p20 = cu[2] * cv[0];
        p02 = cu[0] * cv[2];
        area = $signed({3'h0, p01}) - $signed({3'h0, p10})
             + $signed({3'h0, p12}) - $signed({3'h0, p21})
             + $signed({3'h0, p20}) - $signed({3'h0, p02});
        swap = (state_ff != ST_ISO)
            && ((cw_ff && area > 35'sh0) || (!cw_ff && area < 35'sh0));
    end

    // generator state registers
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_ff <= ST_IDLE;
            a_ff <= 7'h00;
            b_ff <= 7'h00;
            side_ff <= 2'h0;
            half_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            a_ff <= nxt_a;
            b_ff <= nxt_b;
            side_ff <= nxt_side;
            half_ff <= nxt_half;
        end
    end

    // patch configuration captured at acceptance
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            m_ff <= 7'h01;
            n_ff <= 7'h01;
            em_ff <= 1'b0;
            en_ff <= 1'b0;
            iso_ff <= 1'b0;
            cw_ff <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                out_ff[i] <= 7'h01;
            end
        end else if (accept) begin
            m_ff <= nxt_m;
            n_ff <= nxt_n;
            em_ff <= odd && (l_in0 == 7'h01);
            en_ff <= odd && (l_in1 == 7'h01);
            iso_ff <= ctrl_ff[CTRL_ISO_BIT];
            cw_ff <= ctrl_ff[CTRL_CW_BIT];
            for (int i = 0; i < 4; i++) begin
                out_ff[i] <= l_out[i];
            end
        end
    end

    // output slot: loaded when empty or drained
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ovalid_ff <= 1'b0;
            oline_ff <= 1'b0;
            olast_ff <= 1'b0;
            for (int i = 0; i < NVERT; i++) begin
                ou_ff[i] <= CRD_ZERO;
                ov_ff[i] <= CRD_ZERO;
            end
        end else if (advance) begin
            ovalid_ff <= 1'b1;
            oline_ff <= iso_ff;
            olast_ff <= (nxt_state == ST_IDLE);
            ou_ff[0] <= cu[0];
            ov_ff[0] <= cv[0];
            ou_ff[1] <= swap ? cu[2] : cu[1];
            ov_ff[1] <= swap ? cv[2] : cv[1];
            ou_ff[2] <= swap ? cu[1] : cu[2];
            ov_ff[2] <= swap ? cv[1] : cv[2];
        end else if (fire) begin
            ovalid_ff <= 1'b0;
        end
    end

    // control register and delivered-primitive counter
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_ff <= CTRL_RST;
            count_ff <= 32'h0;
        end else begin
            if (REG_WR && REG_ADDR == REG_CTRL_OFS) begin
                ctrl_ff <= REG_WDATA[3:0];
            end
            // a delivery in the clearing cycle still counts
            if (REG_WR && REG_ADDR == REG_COUNT_OFS) begin
                count_ff <= fire ? 32'h1 : 32'h0;
            end else if (fire) begin
                count_ff <= count_ff + 32'h1;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 32'h0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL_OFS:   rdata_ff <= {28'h0, ctrl_ff};
                REG_STATUS_OFS: rdata_ff <= {30'h0, state_ff == ST_IDLE,
                                             state_ff != ST_IDLE || ovalid_ff};
                REG_COUNT_OFS:  rdata_ff <= count_ff;
                default:        rdata_ff <= 32'h0;
            endcase
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign OUT_VALID = ovalid_ff;
    assign OUT_IS_LINE = oline_ff;
    assign OUT_LAST = olast_ff;
    assign OUT_U0 = ou_ff[0];
    assign OUT_V0 = ov_ff[0];
    assign OUT_U1 = ou_ff[1];
    assign OUT_V1 = ov_ff[1];
    assign OUT_U2 = ou_ff[2];
    assign OUT_V2 = ov_ff[2];

endmodule
`default_nettype wire

// ---- hw/tq_tess_end.sv ----
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire
